//--- rtl/sspt_defines.svh
`ifndef SSPT_DEFINES_SVH
`define SSPT_DEFINES_SVH

// word length: position bits plus error and warning flags
`define SSPT_POS_BITS 27
`define SSPT_WORD_BITS 29
// recovery interval in nanoseconds
`define SSPT_RECOVERY_NS 12000
// system clock period in nanoseconds
`define SSPT_CLK_NS 100
// recovery counted in system clocks, rounded up
`define SSPT_RECOVERY_CYC \
  ((`SSPT_RECOVERY_NS + `SSPT_CLK_NS - 1) / `SSPT_CLK_NS)
`define SSPT_BUF_DEPTH 2
// system clocks between two publishes; must exceed the busy sync delay
`define SSPT_GUARD_CYC 4

`endif

//--- rtl/sspt_pkg.sv
package sspt_pkg;
  typedef enum logic [1:0] {
    SSPT_IDLE,
    SSPT_SHIFT,
    SSPT_RECOVER
  } sspt_state_t;
endpackage

//--- rtl/sspt_buf.sv
// two-entry skid buffer
module sspt_buf #(
  parameter int WIDTH = 29
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] mem_reg [0:1];
  logic [WIDTH-1:0] mem_next [0:1];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  assign o_ready = (cnt_reg != 2'h2);
  assign o_valid = (cnt_reg != 2'h0);
  assign o_data = mem_reg[0];

  always_comb begin
    logic push;
    logic pop;
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    mem_next[0] = mem_reg[0];
    mem_next[1] = mem_reg[1];
    cnt_next = cnt_reg;
    if (pop) begin
      mem_next[0] = mem_reg[1];
    end
    if (push) begin
      if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) begin
        mem_next[0] = i_data;
      end else begin
        mem_next[1] = i_data;
      end
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      cnt_reg <= 2'h0;
    end else begin
      mem_reg[0] <= mem_next[0];
      mem_reg[1] <= mem_next[1];
      cnt_reg <= cnt_next;
    end
  end
endmodule

//--- rtl/sspt_top.sv
// Operation
// - data only leaves the encoder; nothing is received on the link
// - first falling clock edge latches position, held for the transfer
// - following rising edge starts driving the word, msb first
// - error and warning bits are active low, 1 means no condition
// - one bit per rising edge down to lsb; n bits take n rising edges after the latching fall
// - extra clocks beyond the word shift out trailing zeros
// - after last clock wait recovery, then drive data high
`include "sspt_defines.svh"
module sspt_top #(
  parameter int POS_BITS = `SSPT_POS_BITS,
  parameter int RECOVERY_CYC = `SSPT_RECOVERY_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic [POS_BITS-1:0] i_position,
  input wire logic i_pos_valid,
  output logic o_pos_ready,
  input wire logic i_error,
  input wire logic i_warning,
  output logic o_data,
  output logic o_busy,
  output logic o_words_sent_pulse
);
  localparam int WORD_BITS = POS_BITS + 2;
  localparam int CW = $clog2(WORD_BITS + 1);
  localparam int RW = $clog2(RECOVERY_CYC + 1);
  localparam int GW = $clog2(`SSPT_GUARD_CYC + 1);

  initial begin
    if (POS_BITS < 1 || RECOVERY_CYC < 1) begin
      $error("sspt_top: bad parameters");
    end
  end

  // position source buffered so a stall loses no sample
  logic buf_valid;
  logic buf_ready;
  logic [WORD_BITS-1:0] buf_data;
  logic [WORD_BITS-1:0] src_word;

  assign src_word = {i_position, ~i_error, ~i_warning};

  sspt_buf #(
    .WIDTH(WORD_BITS)
  ) u_buf (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_valid(i_pos_valid),
    .o_ready(o_pos_ready),
    .i_data(src_word),
    .o_valid(buf_valid),
    .i_ready(buf_ready),
    .o_data(buf_data)
  );

  // two published slots; the link picks one by index at its first fall.
  // the slot in use is never rewritten while a read may still pick it
  logic [WORD_BITS-1:0] slot_reg [0:1];
  logic [WORD_BITS-1:0] slot_next [0:1];
  logic pub_reg;
  logic pub_next;
  logic [GW-1:0] guard_reg;
  logic [GW-1:0] guard_next;

  // reset copy for the link flops, released while the link idles
  logic lrst_reg;

  // system side: synchronisers
  logic lclk_s1_reg;
  logic lclk_s2_reg;
  logic ftg_s1_reg;
  logic ftg_s2_reg;
  logic full_s1_reg;
  logic full_s2_reg;

  // system side: control
  sspt_pkg::sspt_state_t state_reg;
  sspt_pkg::sspt_state_t state_next;
  logic [RW-1:0] rec_reg;
  logic [RW-1:0] rec_next;
  logic done_tg_reg;
  logic done_tg_next;
  logic done_reg;
  logic done_next;

  // link side: falling-edge group
  logic frame_tg_reg;
  logic frame_tg_next;
  logic sel_reg;
  logic sel_next;

  // link side: rising-edge group
  logic seen_tg_reg;
  logic seen_tg_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic bit_reg;
  logic bit_next;
  logic full_reg;
  logic full_next;
  logic [WORD_BITS-1:0] word_lk;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lrst_reg <= 1'b1;
      lclk_s1_reg <= 1'b1;
      lclk_s2_reg <= 1'b1;
      ftg_s1_reg <= 1'b0;
      ftg_s2_reg <= 1'b0;
      full_s1_reg <= 1'b0;
      full_s2_reg <= 1'b0;
    end else begin
      lrst_reg <= 1'b0;
      lclk_s1_reg <= i_link_clk;
      lclk_s2_reg <= lclk_s1_reg;
      ftg_s1_reg <= frame_tg_reg;
      ftg_s2_reg <= ftg_s1_reg;
      full_s1_reg <= full_reg;
      full_s2_reg <= full_s1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    slot_next[0] = slot_reg[0];
    slot_next[1] = slot_reg[1];
    pub_next = pub_reg;
    guard_next = guard_reg;
    rec_next = rec_reg;
    done_tg_next = done_tg_reg;
    done_next = 1'b0;
    buf_ready = 1'b0;
    if (guard_reg != '0) begin
      guard_next = guard_reg - GW'(1);
    end
    case (state_reg)
      sspt_pkg::SSPT_IDLE: begin
        if (ftg_s2_reg != done_tg_reg) begin
          state_next = sspt_pkg::SSPT_SHIFT;
          rec_next = '0;
        end else if (guard_reg == '0) begin
          buf_ready = 1'b1;
          if (buf_valid) begin
            // fill the idle slot, then point the link at it
            if (pub_reg) begin
              slot_next[0] = buf_data;
            end else begin
              slot_next[1] = buf_data;
            end
            pub_next = !pub_reg;
            guard_next = GW'(`SSPT_GUARD_CYC);
          end
        end
      end
      sspt_pkg::SSPT_SHIFT: begin
        rec_next = '0;
        if (lclk_s2_reg) begin
          state_next = sspt_pkg::SSPT_RECOVER;
        end
      end
      sspt_pkg::SSPT_RECOVER: begin
        if (!lclk_s2_reg) begin
          state_next = sspt_pkg::SSPT_SHIFT;
          rec_next = '0;
        end else if (rec_reg == RW'(RECOVERY_CYC - 1)) begin
          state_next = sspt_pkg::SSPT_IDLE;
          done_tg_next = ftg_s2_reg;
          done_next = full_s2_reg;
        end else begin
          rec_next = rec_reg + RW'(1);
        end
      end
      default: begin
        state_next = sspt_pkg::SSPT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
      pub_reg <= 1'b0;
      guard_reg <= '0;
      state_reg <= sspt_pkg::SSPT_IDLE;
      rec_reg <= '0;
      done_tg_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      slot_reg[0] <= slot_next[0];
      slot_reg[1] <= slot_next[1];
      pub_reg <= pub_next;
      guard_reg <= guard_next;
      state_reg <= state_next;
      rec_reg <= rec_next;
      done_tg_reg <= done_tg_next;
      done_reg <= done_next;
    end
  end

  // done toggle is static while the link clock runs; the index
  // resolves during the half period before the first rise
  always_comb begin
    frame_tg_next = frame_tg_reg;
    sel_next = sel_reg;
    if (frame_tg_reg == done_tg_reg) begin
      frame_tg_next = !frame_tg_reg;
      sel_next = pub_reg;
    end
  end

  always_ff @(negedge i_link_clk or posedge lrst_reg) begin
    if (lrst_reg) begin
      frame_tg_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else begin
      frame_tg_reg <= frame_tg_next;
      sel_reg <= sel_next;
    end
  end

  assign word_lk = sel_reg ? slot_reg[1] : slot_reg[0];

  always_comb begin
    seen_tg_next = seen_tg_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    full_next = full_reg;
    if (seen_tg_reg != frame_tg_reg) begin
      // rise after the latch sends the msb
      seen_tg_next = frame_tg_reg;
      bit_next = word_lk[WORD_BITS-1];
      cnt_next = CW'(1);
      full_next = 1'b0;
    end else if (seen_tg_reg != done_tg_reg) begin
      if (cnt_reg < CW'(WORD_BITS)) begin
        bit_next = word_lk[CW'(WORD_BITS - 1) - cnt_reg];
        cnt_next = cnt_reg + CW'(1);
        full_next = (cnt_reg == CW'(WORD_BITS - 1));
      end else begin
        bit_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_link_clk or posedge lrst_reg) begin
    if (lrst_reg) begin
      seen_tg_reg <= 1'b0;
      cnt_reg <= '0;
      bit_reg <= 1'b1;
      full_reg <= 1'b0;
    end else begin
      seen_tg_reg <= seen_tg_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      full_reg <= full_next;
    end
  end

  // output-only line, high outside a read
  assign o_data = (seen_tg_reg != done_tg_reg) ? bit_reg : 1'b1;
  assign o_busy = (state_reg != sspt_pkg::SSPT_IDLE);
  assign o_words_sent_pulse = done_reg;
endmodule

//--- tb/sspt_assertions.sv
module sspt_chk #(parameter int RECOVERY_CYC = 8) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic o_pos_ready,
  input wire logic o_data,
  input wire logic o_busy,
  input wire logic o_words_sent_pulse
);
  int hi_reg;
  int hi_next;
  always_comb hi_next = (o_busy && i_link_clk) ? hi_reg + 1 : 0;
  always_ff @(posedge i_clk) hi_reg <= hi_next;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  rst_out_a: assert property (disable iff (1'b0)
    i_srst |=> o_data && !o_busy && o_pos_ready) else $error("rst");
  idle_high_a: assert property ($fell(o_busy) |-> o_data)
    else $error("idle");
  pulse_one_a: assert property (o_words_sent_pulse |=>
    !o_words_sent_pulse) else $error("pulse");
  pulse_hi_a: assert property (o_words_sent_pulse |-> i_link_clk)
    else $error("pulse clk");
  latch_a: assert property ($fell(i_link_clk) && !o_busy |->
    ##[1:4] o_busy) else $error("latch");
  hold_a: assert property ((o_busy && i_link_clk) [*8] |->
    $stable(o_data)) else $error("hold");
  low_busy_a: assert property (o_busy && !i_link_clk |=> o_busy)
    else $error("busy");
  rec_end_a: assert property (hi_reg > RECOVERY_CYC + 5 |-> !o_busy)
    else $error("recover");
  cover property (o_words_sent_pulse);
  cover property ($rose(o_busy));
  cover property ($fell(o_busy));
endmodule
bind sspt_top sspt_chk #(.RECOVERY_CYC(RECOVERY_CYC)) u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_link_clk(i_link_clk),
  .o_pos_ready(o_pos_ready), .o_data(o_data), .o_busy(o_busy),
  .o_words_sent_pulse(o_words_sent_pulse));

//--- tb/sspt_mst.sv
module sspt_mst (
  output logic o_clk,
  input wire logic i_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_clk = 1'b1;
  task automatic burst(input int n, output logic [31:0] q);
    q = '0;
    #37 o_clk = 1'b0;
    for (int k = 0; k < n; k++) begin
      #16 o_clk = 1'b1;
      #8 q = {q[30:0], i_data};
      if (k < n - 1) #8 o_clk = 1'b0;
    end
  endtask
endmodule

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_srst, i_pos_valid, i_error, i_warning;
  logic [26:0] i_position;
  wire link_clk, o_data, o_busy, o_pulse, o_rdy;
  int bad_count, n_checks, cyc, pulses;
  sspt_top #(.RECOVERY_CYC(8)) u_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_link_clk(link_clk),
    .i_position(i_position), .i_pos_valid(i_pos_valid),
    .o_pos_ready(o_rdy), .i_error(i_error), .i_warning(i_warning),
    .o_data(o_data), .o_busy(o_busy), .o_words_sent_pulse(o_pulse));
  sspt_mst u_mst (.o_clk(link_clk), .i_data(o_data));
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one read; position changes mid-burst to prove the latch holds
  task automatic xfer(input logic [26:0] p, input logic e, w, input int n);
    logic [31:0] q;
    logic [31:0] x;
    int p0;
    x = {3'h0, p, ~e, ~w};
    x = (n >= 29) ? x << (n - 29) : x >> (29 - n);
    @(posedge i_clk);
    i_position <= p;
    i_error <= e;
    i_warning <= w;
    i_pos_valid <= 1'b1;
    repeat (20) @(posedge i_clk);
    p0 = pulses;
    fork
      u_mst.burst(n, q);
      begin
        repeat (1) @(posedge i_clk);
        i_position <= ~p;
      end
    join
    chk(q, x);
    repeat (30) @(posedge i_clk);
    #1;
    chk(o_data, 1'b1);
    chk(pulses - p0, n >= 29);
    $display("test done: read of %0d clocks", n);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    {i_srst, i_pos_valid, i_error, i_warning} = 4'h8;
    i_position = '0;
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({o_data, o_busy, o_pulse, o_rdy}, 4'h9);
    $display("test done: reset");
    xfer(27'h4d2b3c1, 1'b0, 1'b0, 29);
    xfer(27'h7ffffff, 1'b1, 1'b0, 32);
    xfer(27'h0000001, 1'b0, 1'b1, 29);
    xfer(27'h2aaaaaa, 1'b1, 1'b1, 10);
    test_done;
  end
endmodule
